// File: pca_regs.vh
// register addresses, field positions, reset values and timing counts of the counter array
`ifndef CAC_REGS_VH
`define CAC_REGS_VH

`define CAC_ADDR_CTRL 8'hD8
`define CAC_ADDR_MODE 8'hD9
`define CAC_ADDR_CPM0 8'hDA
`define CAC_ADDR_CNT_LO 8'hE9
`define CAC_ADDR_CPL0 8'hEA
`define CAC_ADDR_CNT_HI 8'hF9
`define CAC_ADDR_CPH0 8'hFA

`define CAC_CTRL_RESET 8'h00
`define CAC_MODE_RESET 8'h00
`define CAC_CPM_RESET 7'h00

`define CAC_CTRL_OVF_BIT 7
`define CAC_CTRL_RUN_BIT 6
`define CAC_MODE_IDLE_BIT 7
`define CAC_MODE_TBH_BIT 2
`define CAC_MODE_TBL_BIT 1
`define CAC_MODE_OVFIE_BIT 0
`define CAC_CPM_CMP_BIT 6
`define CAC_CPM_CAPP_BIT 5
`define CAC_CPM_CAPN_BIT 4
`define CAC_CPM_MAT_BIT 3
`define CAC_CPM_TOG_BIT 2
`define CAC_CPM_PWM_BIT 1
`define CAC_CPM_IE_BIT 0

`define CAC_NUM_MOD 5
`define CAC_DIV_SLOW 4'd12
`define CAC_DIV_FAST 4'd4
`define CAC_TB_DIV12 2'h0
`define CAC_TB_DIV4 2'h1
`define CAC_TB_T0 2'h2
`define CAC_TB_EXT 2'h3

`endif

// File: pca_module.v
// one compare module: software timer, high-speed toggle output and 8-bit pwm
`timescale 1ns/1ns
`default_nettype none
`include "pca_regs.vh"

module cac_module
(
    input wire i_clk,
    input wire i_rst_n,
    input wire i_tick,
    input wire [15:0] i_count,
    input wire [6:0] i_mode,
    input wire i_wr_lo,
    input wire i_wr_hi,
    input wire [7:0] i_wdata,
    output reg [7:0] o_cmp_lo,
    output reg [7:0] o_cmp_hi,
    output reg o_pin,
    output reg o_match
);

    wire cmp_en;
    wire mat_en;
    wire tog_en;
    wire pwm_en;
    wire cap_any;
    wire timer_mode;
    wire hso_mode;
    wire pwm_mode;

    assign cmp_en = i_mode[`CAC_CPM_CMP_BIT];
    assign mat_en = i_mode[`CAC_CPM_MAT_BIT];
    assign tog_en = i_mode[`CAC_CPM_TOG_BIT];
    assign pwm_en = i_mode[`CAC_CPM_PWM_BIT];
    assign cap_any = i_mode[`CAC_CPM_CAPP_BIT] | i_mode[`CAC_CPM_CAPN_BIT];
    assign timer_mode = cmp_en & mat_en & ~tog_en & ~pwm_en & ~cap_any;
    assign hso_mode = cmp_en & mat_en & tog_en & ~pwm_en & ~cap_any;
    assign pwm_mode = cmp_en & pwm_en & ~tog_en & ~cap_any;

    // =========================================
    // compare registers and output pin
    // the counter moves only on ticks, so a match is acted on once per count value
    always @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_cmp_lo <= 8'h00;
            o_cmp_hi <= 8'h00;
            o_pin <= 1'b0;
            o_match <= 1'b0;
        end
        else
        begin
            o_match <= 1'b0;
            if (i_wr_hi)
                o_cmp_hi <= i_wdata;
            if (i_wr_lo)
                o_cmp_lo <= i_wdata;
            if (i_tick)
            begin
                if ((timer_mode || hso_mode) && i_count == {o_cmp_hi, o_cmp_lo})
                    o_match <= 1'b1;
                if (hso_mode && i_count == {o_cmp_hi, o_cmp_lo})
                    o_pin <= ~o_pin;
                if (pwm_mode)
                begin
                    if (i_count[7:0] == 8'hFF)
                    begin
                        o_pin <= 1'b0;
                        o_cmp_lo <= i_wr_hi ? i_wdata : o_cmp_hi;
                    end
                    else if (i_count[7:0] == o_cmp_lo)
                        o_pin <= 1'b1;
                end
            end
        end
    end

endmodule
`default_nettype wire

// File: pca_top.v
// counter array: 16-bit timebase counter, control/mode registers, five compare modules
`timescale 1ns/1ns
`default_nettype none
`include "pca_regs.vh"

// Functional notes
// - software timer: counter equal to compare value sets event flag, interrupt if enabled
// - event flag survives interrupt entry; only a software write of zero clears it
// - software timer selected by comparator and match enables, toggle and pwm clear
// - high-speed output: pin inverts on each counter match with compare value
// - high-speed output selected by toggle, match and comparator enables all set
// - pwm: pin goes high when counter low byte equals compare low byte
// - pwm: pin goes low on counter low byte overflow, period 256 ticks
// - pwm: on low byte wrap, compare high byte copies into compare low byte
// - pwm selected by comparator and pwm enables, match enable ignored
// - all pwm outputs run from the one shared counter and its timebase
// - counter is two readable bytes forming one 16-bit up-counter
// - low byte read latches high byte; later high byte read returns it
// - counter reads never disturb counting
// - timebase: clock/12, clock/4, timer 0 overflow, external input falling edges
// - counter wrap from all ones sets overflow flag, interrupt if enabled
// - overflow raises an interrupt only while its enable bit is one
// - overflow flag survives interrupt entry; software must clear it
// - overflow interrupt needs global and array interrupt enables both set
// - with idle suspend clear, the array keeps running in processor idle
module cac_top
(
    input wire I_CLK,
    input wire I_RST_N,
    input wire [7:0] I_SFR_ADDR,
    input wire I_SFR_WR,
    input wire I_SFR_RD,
    input wire [7:0] I_SFR_WDATA,
    input wire I_T0_OVF,
    input wire I_EXT_COUNT,
    input wire I_CORE_IDLE,
    input wire I_GLOBAL_IRQ_EN,
    input wire I_ARRAY_IRQ_EN,
    output reg [7:0] O_SFR_RDATA,
    output reg [4:0] O_MODULE_IO_PIN,
    output reg O_IRQ
);

    // =========================================
    // address decode helper
    function [2:0] mod_index;
        input [7:0] addr;
        input [7:0] base;
        begin
            mod_index = 3'd7;
            if (addr >= base && addr < base + 8'd5)
                mod_index = addr[2:0] - base[2:0];
        end
    endfunction

    reg [7:0] ctrl_reg;
    reg [7:0] mode_reg;
    reg [6:0] cpm_reg [0:4];
    reg [15:0] count_reg;
    reg [7:0] hi_latch_reg;
    reg [3:0] div_reg;
    reg ext_prev_reg;
    reg [4:0] wr_lo;
    reg [4:0] wr_hi;
    reg [7:0] rdata_next;
    reg tick;
    wire run;
    wire [4:0] match;
    wire [4:0] pin;
    wire [7:0] cmp_lo [0:4];
    wire [7:0] cmp_hi [0:4];
    wire [2:0] lo_idx;
    wire [2:0] hi_idx;
    wire [2:0] cpm_idx;
    wire [1:0] tb_sel;
    wire ovf;
    wire [3:0] div_max;
    integer k;
    integer j;

    assign tb_sel = {mode_reg[`CAC_MODE_TBH_BIT], mode_reg[`CAC_MODE_TBL_BIT]};
    assign run = ctrl_reg[`CAC_CTRL_RUN_BIT] &
                 ~(mode_reg[`CAC_MODE_IDLE_BIT] & I_CORE_IDLE);
    assign lo_idx = mod_index(I_SFR_ADDR, `CAC_ADDR_CPL0);
    assign hi_idx = mod_index(I_SFR_ADDR, `CAC_ADDR_CPH0);
    assign cpm_idx = mod_index(I_SFR_ADDR, `CAC_ADDR_CPM0);
    assign div_max = (tb_sel == `CAC_TB_DIV12) ? `CAC_DIV_SLOW - 4'd1 : `CAC_DIV_FAST - 4'd1;
    assign ovf = tick && count_reg == 16'hFFFF;

    // =========================================
    // timebase select
    // external edges are only seen once per clock, so the source must stay at or below clock/2
    always @*
    begin
        tick = 1'b0;
        if (run)
        begin
            if (tb_sel == `CAC_TB_T0)
                tick = I_T0_OVF;
            else if (tb_sel == `CAC_TB_EXT)
                tick = ext_prev_reg & ~I_EXT_COUNT;
            else
                tick = (div_reg == div_max);
        end
    end

    always @(posedge I_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            div_reg <= 4'h0;
            ext_prev_reg <= 1'b1;
            count_reg <= 16'h0000;
        end
        else
        begin
            ext_prev_reg <= I_EXT_COUNT;
            if (!run || div_reg >= div_max)
                div_reg <= 4'h0;
            else
                div_reg <= div_reg + 4'h1;
            // software writes to the counter bytes are not allowed; reads leave it alone
            if (tick)
                count_reg <= count_reg + 16'h0001;
        end
    end

    // =========================================
    // write strobes for compare bytes
    always @*
    begin
        wr_lo = 5'h00;
        wr_hi = 5'h00;
        if (I_SFR_WR && lo_idx < 3'd5)
            wr_lo[lo_idx] = 1'b1;
        if (I_SFR_WR && hi_idx < 3'd5)
            wr_hi[hi_idx] = 1'b1;
    end

    // =========================================
    // compare modules share one counter
    genvar g;
    generate
        for (g = 0; g < `CAC_NUM_MOD; g = g + 1)
        begin : g_mod
            cac_module u_mod
            (
                .i_clk(I_CLK),
                .i_rst_n(I_RST_N),
                .i_tick(tick),
                .i_count(count_reg),
                .i_mode(cpm_reg[g]),
                .i_wr_lo(wr_lo[g]),
                .i_wr_hi(wr_hi[g]),
                .i_wdata(I_SFR_WDATA),
                .o_cmp_lo(cmp_lo[g]),
                .o_cmp_hi(cmp_hi[g]),
                .o_pin(pin[g]),
                .o_match(match[g])
            );
        end
    endgenerate

    // =========================================
    // control, mode and module mode registers
    always @(posedge I_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            ctrl_reg <= `CAC_CTRL_RESET;
            mode_reg <= `CAC_MODE_RESET;
            hi_latch_reg <= 8'h00;
            for (k = 0; k < 5; k = k + 1)
                cpm_reg[k] <= `CAC_CPM_RESET;
        end
        else
        begin
            if (I_SFR_WR && I_SFR_ADDR == `CAC_ADDR_CTRL)
                ctrl_reg <= {I_SFR_WDATA[7:6], 1'b0, I_SFR_WDATA[4:0]};
            else if (I_SFR_WR && I_SFR_ADDR == `CAC_ADDR_MODE)
                mode_reg <= {I_SFR_WDATA[7], 4'h0, I_SFR_WDATA[2:0]};
            else if (I_SFR_WR && cpm_idx < 3'd5)
                cpm_reg[cpm_idx] <= I_SFR_WDATA[6:0];
            // hardware sets win over a same-cycle software clear
            for (k = 0; k < 5; k = k + 1)
                if (match[k])
                    ctrl_reg[k] <= 1'b1;
            if (ovf)
                ctrl_reg[`CAC_CTRL_OVF_BIT] <= 1'b1;
            if (I_SFR_RD && I_SFR_ADDR == `CAC_ADDR_CNT_LO)
                hi_latch_reg <= count_reg[15:8];
        end
    end

    // =========================================
    // read data, pins and interrupt
    always @*
    begin
        rdata_next = 8'h00;
        if (I_SFR_ADDR == `CAC_ADDR_CTRL)
            rdata_next = ctrl_reg;
        else if (I_SFR_ADDR == `CAC_ADDR_MODE)
            rdata_next = mode_reg;
        else if (I_SFR_ADDR == `CAC_ADDR_CNT_LO)
            rdata_next = count_reg[7:0];
        else if (I_SFR_ADDR == `CAC_ADDR_CNT_HI)
            rdata_next = hi_latch_reg;
        else if (cpm_idx < 3'd5)
            rdata_next = {1'b0, cpm_reg[cpm_idx]};
        else if (lo_idx < 3'd5)
            rdata_next = cmp_lo[lo_idx];
        else if (hi_idx < 3'd5)
            rdata_next = cmp_hi[hi_idx];
    end

    reg irq_next;
    always @*
    begin
        irq_next = ctrl_reg[`CAC_CTRL_OVF_BIT] & mode_reg[`CAC_MODE_OVFIE_BIT];
        for (j = 0; j < 5; j = j + 1)
            irq_next = irq_next | (ctrl_reg[j] & cpm_reg[j][`CAC_CPM_IE_BIT]);
        irq_next = irq_next & I_GLOBAL_IRQ_EN & I_ARRAY_IRQ_EN;
    end

    always @(posedge I_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            O_SFR_RDATA <= 8'h00;
            O_MODULE_IO_PIN <= 5'h00;
            O_IRQ <= 1'b0;
        end
        else
        begin
            O_SFR_RDATA <= rdata_next;
            O_MODULE_IO_PIN <= pin;
            O_IRQ <= irq_next;
        end
    end

endmodule
`default_nettype wire

// File: cac_checker_sva.sv
// assertion checker on the counter array top-level ports
`timescale 1ns/1ns
`default_nettype none
module cac_checker
(
    input wire I_CLK,
    input wire I_RST_N,
    input wire [7:0] I_SFR_ADDR,
    input wire I_SFR_WR,
    input wire I_GLOBAL_IRQ_EN,
    input wire I_ARRAY_IRQ_EN,
    input wire [7:0] O_SFR_RDATA,
    input wire [4:0] O_MODULE_IO_PIN,
    input wire O_IRQ
);
    default clocking @(posedge I_CLK); endclocking
    default disable iff (!I_RST_N);
    // =========================================
    // two back-to-back control reads with no write that could clear a flag
    sequence ctl_reread;
        $past(I_SFR_ADDR) == 8'hD8 && $past(I_SFR_ADDR, 2) == 8'hD8
            && !$past(I_SFR_WR) && !$past(I_SFR_WR, 2) && !$past(I_SFR_WR, 3);
    endsequence
    irq_gate_a: assert property (O_IRQ |-> $past(I_GLOBAL_IRQ_EN && I_ARRAY_IRQ_EN))
        else $error("interrupt raised without both enables");
    irq_drop_a: assert property (!I_GLOBAL_IRQ_EN |=> !O_IRQ)
        else $error("interrupt stayed up after global enable dropped");
    ovf_sticky_a: assert property (ctl_reread |-> O_SFR_RDATA[7] || !$past(O_SFR_RDATA[7]))
        else $error("overflow flag dropped without a write");
    evt_sticky_a: assert property (ctl_reread |->
        (O_SFR_RDATA[4:0] & $past(O_SFR_RDATA[4:0])) == $past(O_SFR_RDATA[4:0]))
        else $error("event flag dropped without a write");
    ctrl_unused_a: assert property ($past(I_SFR_ADDR) == 8'hD8 |-> !O_SFR_RDATA[5])
        else $error("control bit 5 read as one");
    mode_unused_a: assert property ($past(I_SFR_ADDR) == 8'hD9 |-> O_SFR_RDATA[6:3] == 4'h0)
        else $error("mode unused bits read nonzero");
    cpm_unused_a: assert property ($past(I_SFR_ADDR) inside {[8'hDA:8'hDE]} |-> !O_SFR_RDATA[7])
        else $error("module mode bit 7 read as one");
    unmapped_zero_a: assert property ($past(I_SFR_ADDR) == 8'h00 |-> O_SFR_RDATA == 8'h00)
        else $error("unmapped address read nonzero");
    cover property (O_IRQ);
    cover property ($changed(O_MODULE_IO_PIN));
    cover property ($past(I_SFR_ADDR) == 8'hD8 && O_SFR_RDATA[0]);
endmodule
`default_nettype wire

// File: cac_src_model.sv
// timer 0 overflow strobe and external count source feeding the array
`timescale 1ns/1ns
`default_nettype none
module cac_src_model
(
    input wire logic i_clk,
    output logic o_t0_ovf,
    output logic o_ext_count
);
    logic [2:0] ph_reg = 3'h0;
    logic [2:0] q_reg = 3'h0;
    always @(negedge i_clk)
    begin
        ph_reg <= (ph_reg == 3'h5) ? 3'h0 : ph_reg + 3'h1;
        q_reg <= q_reg + 3'h1;
    end
    // one strobe in six clocks; count input falls once in eight, slower than clock/4
    assign o_t0_ovf = (ph_reg == 3'h5);
    assign o_ext_count = ~q_reg[2];
endmodule
`default_nettype wire

// File: test_counter_array_compare_pwm.sv
// self-checking bench: timer, toggle, pwm, counter bytes and timebase
`timescale 1ns/1ns
`default_nettype none
module test_counter_array_compare_pwm;
    // {idle suspend, core idle, timebase select} per timebase run
    localparam logic [23:0] TBL = 24'h0523D9;
    logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, idle = 1'b0, gie = 1'b1, aie = 1'b1;
    logic [7:0] addr = 8'h00, wdata = 8'h00, d, v;
    logic [15:0] c0, c1, xt;
    logic [3:0] e;
    wire t0_ovf, ext_cnt, irq;
    wire [7:0] rdata;
    wire [4:0] pins;
    integer fails = 0, tests_run = 0, i, n;
    cac_top dut_u (.I_CLK(clk), .I_RST_N(rst_n), .I_SFR_ADDR(addr), .I_SFR_WR(wr),
        .I_SFR_RD(rd), .I_SFR_WDATA(wdata), .I_T0_OVF(t0_ovf), .I_EXT_COUNT(ext_cnt),
        .I_CORE_IDLE(idle), .I_GLOBAL_IRQ_EN(gie), .I_ARRAY_IRQ_EN(aie),
        .O_SFR_RDATA(rdata), .O_MODULE_IO_PIN(pins), .O_IRQ(irq));
    cac_src_model src_u (.i_clk(clk), .o_t0_ovf(t0_ovf), .o_ext_count(ext_cnt));
    initial forever #25 clk = ~clk;
    function automatic logic [15:0] exp_ticks(input logic [3:0] m, input integer cyc);
        if (m[3] && m[2])
            return 16'h0;
        case (m[1:0])
            2'h0: return cyc / 12;
            2'h1: return cyc / 4;
            2'h2: return cyc / 6;
            default: return cyc / 8;
        endcase
    endfunction
    task automatic chk(input string what, input logic [15:0] ex, input logic [15:0] got);
        tests_run = tests_run + 1;
        if (ex !== got)
        begin
            fails = fails + 1;
            $display("CHECK FAILED %s expected %h seen %h", what, ex, got);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] dv);
        @(negedge clk);
        addr = a;
        wdata = dv;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask
    // data registered one cycle behind the address, so hold it two edges
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] dv);
        @(negedge clk);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        @(negedge clk);
        dv = rdata;
    endtask
    task automatic rd_cnt(output logic [15:0] c);
        rd_reg(8'hE9, c[7:0]);
        rd_reg(8'hF9, c[15:8]);
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial
    begin
        #2_000_000;
        fails = fails + 1;
        $display("CHECK FAILED watchdog expected finish seen timeout");
        results;
    end
    initial
    begin
        d = 8'($urandom(32'hD3FE));
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        for (i = 0; i < 4; i = i + 1)
        begin
            rd_reg(8'hD8 + i[7:0] - ((i == 3) ? 8'hDB : 8'h00), d);
            chk("reset read", 16'h0, d);
        end
        $display("test reset done");
        v = 8'h10 + 8'($urandom % 160);
        wr_reg(8'hD9, 8'h02);
        wr_reg(8'hDA, 8'h49);
        wr_reg(8'hDB, 8'h4C);
        wr_reg(8'hEA, v);
        wr_reg(8'hEB, v);
        wr_reg(8'hD8, 8'h40);
        n = 0;
        d = 8'h00;
        while (d[0] !== 1'b1 && n < 400)
        begin
            rd_reg(8'hD8, d);
            n = n + 1;
        end
        chk("match time", 16'h1, (n * 3 + 8 >= 4 * v) && (n * 3 <= 4 * v + 12));
        chk("event flags", 16'h3, d[1:0]);
        repeat (2) @(negedge clk);
        chk("toggle pin", 16'h2, pins[1:0]);
        chk("irq", 16'h1, irq);
        gie = 1'b0;
        repeat (2) @(negedge clk);
        chk("irq masked", 16'h0, irq);
        gie = 1'b1;
        rd_reg(8'hD8, d);
        chk("flag held", 16'h1, d[0]);
        wr_reg(8'hD8, 8'h40);
        rd_reg(8'hD8, d);
        chk("flag cleared", 16'h0, d[1:0]);
        $display("test timer done");
        v = 8'h10 + 8'($urandom % 200);
        wr_reg(8'hFC, v);
        wr_reg(8'hDC, 8'h4A);
        repeat (2048) @(negedge clk);
        n = 0;
        for (i = 0; i < 1024; i = i + 1)
        begin
            @(negedge clk);
            n = n + (pins[2] === 1'b1);
        end
        chk("pwm high", (255 - v) * 4, n);
        rd_reg(8'hEC, d);
        chk("pwm reload", v, d);
        $display("test pwm done");
        wr_reg(8'hD8, 8'h00);
        rd_cnt(c0);
        wr_reg(8'hD8, 8'h40);
        repeat (1100) @(negedge clk);
        wr_reg(8'hD8, 8'h00);
        rd_reg(8'hF9, d);
        chk("latched high", c0[15:8], d);
        rd_cnt(c1);
        c1 = c1 - c0;
        chk("run ticks", 16'h1, c1 >= 16'd274 && c1 <= 16'd277);
        $display("test counter done");
        for (i = 0; i < 6; i = i + 1)
        begin
            e = TBL[23 - 4 * i -: 4];
            wr_reg(8'hD9, {e[3], 4'h0, e[1:0], 1'b0});
            idle = e[2];
            rd_cnt(c0);
            wr_reg(8'hD8, 8'h40);
            repeat (479) @(negedge clk);
            wr_reg(8'hD8, 8'h00);
            rd_cnt(c1);
            xt = exp_ticks(e, 480);
            c1 = c1 - c0;
            chk("timebase ticks", 16'h1, c1 + 16'd1 >= xt && c1 <= xt + 16'd1);
        end
        $display("test timebase done");
        results;
    end
endmodule
bind cac_top cac_checker chk_u (.I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_SFR_ADDR(I_SFR_ADDR),
    .I_SFR_WR(I_SFR_WR), .I_GLOBAL_IRQ_EN(I_GLOBAL_IRQ_EN), .I_ARRAY_IRQ_EN(I_ARRAY_IRQ_EN),
    .O_SFR_RDATA(O_SFR_RDATA), .O_MODULE_IO_PIN(O_MODULE_IO_PIN), .O_IRQ(O_IRQ));
`default_nettype wire
